// ### verilog/sense_pkg.sv
package sense_pkg;
  localparam logic [7:0] OP_TEST_READY = 8'h00;
  localparam logic [7:0] OP_REQ_SENSE = 8'h03;
  localparam logic [7:0] OP_SELF_DIAG = 8'h1D;
  localparam logic [4:0] ST_GOOD = 5'h00;
  localparam logic [4:0] ST_CHECK = 5'h01;
  localparam logic [7:0] MSG_COMPLETE = 8'h00;
  localparam logic [7:0] SENSE_HEAD = 8'hF0;
  localparam logic [7:0] ADD_SENSE_LEN = 8'h0A;
  localparam int SENSE_BYTES = 18;
  localparam logic [7:0] IDX_KEY = 8'h02;
  localparam logic [7:0] IDX_INFO0 = 8'h03;
  localparam logic [7:0] IDX_ADD_LEN = 8'h07;
  localparam logic [7:0] IDX_ASC = 8'h0C;
  localparam logic [7:0] IDX_ASCQ = 8'h0D;
  localparam logic [7:0] ADR_ERROR = 8'h00;
  localparam logic [7:0] ADR_REQ_CNT = 8'h04;
  localparam logic [7:0] ADR_ACT_CNT = 8'h08;
  localparam logic [7:0] ADR_STATE = 8'h0C;
  localparam int ERR_POST_BIT = 31;
  localparam int ERR_ILI_BIT = 8;
  localparam logic [2:0] PH_FREE = 3'h0;
  localparam logic [2:0] PH_DATA_IN = 3'h1;
  localparam logic [2:0] PH_STATUS = 3'h3;
  localparam logic [2:0] PH_MSG_IN = 3'h7;
  localparam logic [4:0] CAUSE_NONE = 5'h00;
  localparam logic [4:0] CAUSE_NOT_READY = 5'h01;
  localparam logic [4:0] CAUSE_INTERLOCK = 5'h02;
  localparam logic [4:0] CAUSE_JAM = 5'h03;
  localparam logic [4:0] CAUSE_COVER_OPEN = 5'h04;
  localparam logic [4:0] CAUSE_CHUTE_EMPTY = 5'h05;
  localparam logic [4:0] CAUSE_SEP_SHEET = 5'h06;
  localparam logic [4:0] CAUSE_FUSE_CARRIAGE = 5'h07;
  localparam logic [4:0] CAUSE_FUSE_HEATER = 5'h08;
  localparam logic [4:0] CAUSE_FUSE_LAMP = 5'h09;
  localparam logic [4:0] CAUSE_FUSE_FEEDER = 5'h0A;
  localparam logic [4:0] CAUSE_MECH_ALARM = 5'h0B;
  localparam logic [4:0] CAUSE_OPT_ALARM = 5'h0C;
  localparam logic [4:0] CAUSE_TARGET_FAULT = 5'h0D;
  localparam logic [4:0] CAUSE_PARITY = 5'h0E;
  localparam logic [4:0] CAUSE_BAD_OPCODE = 5'h0F;
  localparam logic [4:0] CAUSE_BAD_CDB = 5'h10;
  localparam logic [4:0] CAUSE_BAD_LUN = 5'h11;
  localparam logic [4:0] CAUSE_BAD_PARAM = 5'h12;
  localparam logic [4:0] CAUSE_BAD_WINDOW = 5'h13;
  localparam logic [4:0] CAUSE_UNIT_ATTN = 5'h14;
  localparam logic [4:0] CAUSE_MSG_ERROR = 5'h15;
  localparam logic [4:0] CAUSE_XFER_ERROR = 5'h16;
endpackage

// ### verilog/sense_code_table.sv
`timescale 1ns/1ps
`default_nettype none
module sense_code_table (
  input wire logic [4:0] cause,
  output logic [3:0] key,
  output logic [7:0] asc,
  output logic [7:0] ascq
);
  always_comb begin
    key = 4'h4;
    asc = 8'h44;
    ascq = 8'h00;
    case (cause)
      sense_pkg::CAUSE_NONE: begin key = 4'h0; asc = 8'h00; end
      sense_pkg::CAUSE_NOT_READY: begin key = 4'h2; asc = 8'h00; end
      sense_pkg::CAUSE_INTERLOCK: begin key = 4'h2; asc = 8'h80; ascq = 8'h01; end
      sense_pkg::CAUSE_JAM: begin key = 4'h3; asc = 8'h80; ascq = 8'h01; end
      sense_pkg::CAUSE_COVER_OPEN: begin key = 4'h3; asc = 8'h80; ascq = 8'h02; end
      sense_pkg::CAUSE_CHUTE_EMPTY: begin key = 4'h3; asc = 8'h80; ascq = 8'h03; end
      sense_pkg::CAUSE_SEP_SHEET: begin key = 4'h3; asc = 8'h80; ascq = 8'h04; end
      sense_pkg::CAUSE_FUSE_CARRIAGE: begin asc = 8'h80; ascq = 8'h01; end
      sense_pkg::CAUSE_FUSE_HEATER: begin asc = 8'h80; ascq = 8'h02; end
      sense_pkg::CAUSE_FUSE_LAMP: begin asc = 8'h80; ascq = 8'h03; end
      sense_pkg::CAUSE_FUSE_FEEDER: begin asc = 8'h80; ascq = 8'h04; end
      sense_pkg::CAUSE_MECH_ALARM: begin asc = 8'h80; ascq = 8'h05; end
      sense_pkg::CAUSE_OPT_ALARM: begin asc = 8'h80; ascq = 8'h06; end
      sense_pkg::CAUSE_TARGET_FAULT: begin asc = 8'h44; end
      sense_pkg::CAUSE_PARITY: begin asc = 8'h47; end
      sense_pkg::CAUSE_BAD_OPCODE: begin key = 4'h5; asc = 8'h20; end
      sense_pkg::CAUSE_BAD_CDB: begin key = 4'h5; asc = 8'h24; end
      sense_pkg::CAUSE_BAD_LUN: begin key = 4'h5; asc = 8'h25; end
      sense_pkg::CAUSE_BAD_PARAM: begin key = 4'h5; asc = 8'h26; end
      sense_pkg::CAUSE_BAD_WINDOW: begin key = 4'h5; asc = 8'h2C; ascq = 8'h02; end
      sense_pkg::CAUSE_UNIT_ATTN: begin key = 4'h6; asc = 8'h00; end
      sense_pkg::CAUSE_MSG_ERROR: begin key = 4'hB; asc = 8'h43; end
      sense_pkg::CAUSE_XFER_ERROR: begin key = 4'hB; asc = 8'h80; ascq = 8'h01; end
      // Unknown causes fall back to internal target fault
      default: begin key = 4'h4; asc = 8'h44; ascq = 8'h00; end
    endcase
  end
endmodule
`default_nettype wire

// ### verilog/scsi_sense_diag.sv
// Behaviour
// - Information bytes hold requested minus actual count
// - Additional sense length always reads 0A
// - Command-specific information bytes are always zero
// - No-sense, not-ready, interlock, aborted codes per table
// - Medium error codes 80/01 to 80/04
// - Hardware error codes 80/01-06, 44/00, 47/00
// - Illegal request codes 20,24,25,26,2C/02
// - Opcode 1D goes command to status directly
// - Only built-in self-test is supported
// - PF, offline bits and list length ignored
// - Self-test is NOP; check condition if error pending
// - No pending error gives GOOD, key zero
// - Pending error gives CHECK CONDITION with its key
// - Status, command complete message, then release BSY
// - Unit-ready query answered by status only, no test
// - Sense record built on check condition or bus-free error
// - Sense readout ends at allocation or record length
`timescale 1ns/1ps
`default_nettype none
module scsi_sense_diag #(
  parameter int SENSE_LEN = sense_pkg::SENSE_BYTES
) (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic CMD_VALID,
  input wire logic [7:0] CMD_OPCODE,
  input wire logic [7:0] CMD_ALLOC,
  output logic CMD_READY,
  input wire logic BUS_FREE_ERR,
  output logic [2:0] PHASE,
  output logic BSY,
  output logic TX_VALID,
  output logic [7:0] TX_DATA,
  input wire logic TX_READY
);
  if (SENSE_LEN < 14 || SENSE_LEN > 255) begin : g_len_check
    $error("SENSE_LEN must lie between 14 and 255");
  end

  localparam logic [7:0] SENSE_LEN_B = 8'(SENSE_LEN);

  typedef enum logic [3:0] {
    S_FREE = 4'b0001,
    S_DATA = 4'b0010,
    S_STAT = 4'b0100,
    S_MSG = 4'b1000
  } state_e;

  state_e state_q, state_d;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] req_cnt_q;
  logic [31:0] act_cnt_q;
  logic pend_q;
  logic [4:0] cause_q;
  logic ili_q;
  logic [31:0] info_q;
  logic [7:0] cnt_q, cnt_d;
  logic [7:0] limit_q;
  logic [4:0] status_q, status_d;
  logic [7:0] tx_q;
  logic [3:0] key;
  logic [7:0] asc;
  logic [7:0] ascq;
  logic wb_req, wb_wr;
  logic sw_post, cmd_take, bad_op, last_byte, sense_done;

  sense_code_table u_table (
    .cause(cause_q),
    .key(key),
    .asc(asc),
    .ascq(ascq)
  );

  // Wishbone slave: one wait cycle, ack for one cycle
  assign wb_req = WB_CYC_I && WB_STB_I && !ack_q;
  assign wb_wr = wb_req && WB_WE_I;
  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdata_q;

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_req;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_q <= 32'h0000_0000;
    end else if (wb_req && !WB_WE_I) begin
      case (WB_ADR_I)
        sense_pkg::ADR_ERROR: rdata_q <= {23'h000000, ili_q, pend_q, key, 3'h0};
        sense_pkg::ADR_REQ_CNT: rdata_q <= req_cnt_q;
        sense_pkg::ADR_ACT_CNT: rdata_q <= act_cnt_q;
        sense_pkg::ADR_STATE: rdata_q <= {19'h00000, state_q, status_q, cause_q[3:0]};
        // Unmapped reads answer zero
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      req_cnt_q <= 32'h0000_0000;
      act_cnt_q <= 32'h0000_0000;
    end else begin
      for (int b = 0; b < 4; b++) begin
        if (wb_wr && WB_SEL_I[b] && WB_ADR_I == sense_pkg::ADR_REQ_CNT) begin
          req_cnt_q[b*8 +: 8] <= WB_DAT_I[b*8 +: 8];
        end
        if (wb_wr && WB_SEL_I[b] && WB_ADR_I == sense_pkg::ADR_ACT_CNT) begin
          act_cnt_q[b*8 +: 8] <= WB_DAT_I[b*8 +: 8];
        end
      end
    end
  end

  // Posting needs both end lanes so cause and post bit arrive together
  assign sw_post = wb_wr && WB_ADR_I == sense_pkg::ADR_ERROR && WB_SEL_I[3] &&
                   WB_SEL_I[0] && WB_DAT_I[sense_pkg::ERR_POST_BIT];
  assign cmd_take = state_q == S_FREE && CMD_VALID;
  assign bad_op = CMD_OPCODE != sense_pkg::OP_REQ_SENSE &&
                  CMD_OPCODE != sense_pkg::OP_SELF_DIAG &&
                  CMD_OPCODE != sense_pkg::OP_TEST_READY;
  assign last_byte = state_q == S_DATA && TX_READY && cnt_q == limit_q - 8'h01;
  // Sense counts as delivered when the last data byte is taken, or at once for request sense with allocation zero
  assign sense_done = last_byte ||
                      (cmd_take && CMD_OPCODE == sense_pkg::OP_REQ_SENSE && CMD_ALLOC == 8'h00);

  // Pending error record; a new post beats the clear in the same cycle
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pend_q <= 1'b0;
      cause_q <= sense_pkg::CAUSE_NONE;
      ili_q <= 1'b0;
      info_q <= 32'h0000_0000;
    end else if (sw_post) begin
      pend_q <= 1'b1;
      cause_q <= WB_DAT_I[4:0];
      ili_q <= WB_DAT_I[sense_pkg::ERR_ILI_BIT];
      info_q <= req_cnt_q - act_cnt_q;
    end else if (cmd_take && bad_op) begin
      pend_q <= 1'b1;
      cause_q <= sense_pkg::CAUSE_BAD_OPCODE;
      ili_q <= 1'b0;
    end else if (BUS_FREE_ERR) begin
      pend_q <= 1'b1;
      cause_q <= sense_pkg::CAUSE_MSG_ERROR;
      ili_q <= 1'b0;
    end else if (sense_done) begin
      pend_q <= 1'b0;
      cause_q <= sense_pkg::CAUSE_NONE;
      ili_q <= 1'b0;
    end
  end

  // Phase sequencer; CDB bytes other than opcode and allocation are unused
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    status_d = status_q;
    case (state_q)
      S_FREE: begin
        if (CMD_VALID) begin
          cnt_d = 8'h00;
          state_d = S_STAT;
          // Self-test is a no-op; result is the pending error only
          status_d = pend_q ? sense_pkg::ST_CHECK : sense_pkg::ST_GOOD;
          if (CMD_OPCODE == sense_pkg::OP_REQ_SENSE) begin
            status_d = sense_pkg::ST_GOOD;
            if (CMD_ALLOC != 8'h00) begin
              state_d = S_DATA;
            end
          end else if (bad_op) begin
            status_d = sense_pkg::ST_CHECK;
          end
        end
      end
      S_DATA: begin
        if (TX_READY) begin
          cnt_d = cnt_q + 8'h01;
          if (last_byte) begin
            state_d = S_STAT;
          end
        end
      end
      S_STAT: begin
        if (TX_READY) begin
          state_d = S_MSG;
        end
      end
      S_MSG: begin
        if (TX_READY) begin
          state_d = S_FREE;
        end
      end
      default: state_d = S_FREE;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= S_FREE;
      cnt_q <= 8'h00;
      status_q <= sense_pkg::ST_GOOD;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      status_q <= status_d;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      limit_q <= 8'h00;
    end else if (cmd_take) begin
      limit_q <= (CMD_ALLOC < SENSE_LEN_B) ? CMD_ALLOC : SENSE_LEN_B;
    end
  end

  function automatic logic [7:0] sense_byte(input logic [7:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      8'h00: v = sense_pkg::SENSE_HEAD;
      sense_pkg::IDX_KEY: v = {2'b00, ili_q, 1'b0, key};
      sense_pkg::IDX_INFO0: v = info_q[31:24];
      sense_pkg::IDX_INFO0 + 8'h01: v = info_q[23:16];
      sense_pkg::IDX_INFO0 + 8'h02: v = info_q[15:8];
      sense_pkg::IDX_INFO0 + 8'h03: v = info_q[7:0];
      sense_pkg::IDX_ADD_LEN: v = sense_pkg::ADD_SENSE_LEN;
      sense_pkg::IDX_ASC: v = asc;
      sense_pkg::IDX_ASCQ: v = ascq;
      // Command-specific and reserved bytes read zero
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Byte on the bus is registered from the next state
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      tx_q <= 8'h00;
    end else begin
      case (state_d)
        S_DATA: tx_q <= sense_byte(cnt_d);
        S_STAT: tx_q <= {2'b00, status_d, 1'b0};
        S_MSG: tx_q <= sense_pkg::MSG_COMPLETE;
        default: tx_q <= 8'h00;
      endcase
    end
  end

  assign TX_DATA = tx_q;
  assign TX_VALID = state_q != S_FREE;
  assign BSY = state_q != S_FREE;
  assign CMD_READY = state_q == S_FREE;

  always_comb begin
    case (state_q)
      S_DATA: PHASE = sense_pkg::PH_DATA_IN;
      S_STAT: PHASE = sense_pkg::PH_STATUS;
      S_MSG: PHASE = sense_pkg::PH_MSG_IN;
      default: PHASE = sense_pkg::PH_FREE;
    endcase
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);

  chk_info_bytes: assert property (
    state_q == S_DATA && cnt_q == sense_pkg::IDX_INFO0 |-> TX_DATA == info_q[31:24])
    else $error("information byte wrong");
  chk_add_len_fixed: assert property (
    state_q == S_DATA && cnt_q == sense_pkg::IDX_ADD_LEN |-> TX_DATA == 8'h0A)
    else $error("additional sense length wrong");
  chk_cmd_info_zero: assert property (
    state_q == S_DATA && cnt_q >= 8'h08 && cnt_q <= 8'h0B |-> TX_DATA == 8'h00)
    else $error("command info byte not zero");
  chk_asc_byte: assert property (
    state_q == S_DATA && cnt_q == sense_pkg::IDX_ASC |-> TX_DATA == asc)
    else $error("sense code byte wrong");
  chk_medium_code: assert property (
    key == 4'h3 |-> asc == 8'h80 && ascq >= 8'h01 && ascq <= 8'h04)
    else $error("medium error code wrong");
  chk_hw_code: assert property (
    key == 4'h4 |-> (asc == 8'h80 && ascq >= 8'h01 && ascq <= 8'h06) ||
                    ((asc == 8'h44 || asc == 8'h47) && ascq == 8'h00))
    else $error("hardware error code wrong");
  chk_illegal_code: assert property (
    key == 4'h5 |-> asc inside {8'h20, 8'h24, 8'h25, 8'h26, 8'h2C})
    else $error("illegal request code wrong");
  chk_diag_no_data: assert property (
    cmd_take && CMD_OPCODE == sense_pkg::OP_SELF_DIAG |=> state_q == S_STAT)
    else $error("diagnostic entered data phase");
  chk_diag_status: assert property (
    cmd_take && CMD_OPCODE == sense_pkg::OP_SELF_DIAG |=>
      TX_DATA == {2'b00, ($past(pend_q) ? 5'h01 : 5'h00), 1'b0})
    else $error("diagnostic status wrong");
  chk_ready_query: assert property (
    cmd_take && CMD_OPCODE == sense_pkg::OP_TEST_READY |=> PHASE == sense_pkg::PH_STATUS)
    else $error("unit ready query not status only");
  chk_msg_after_stat: assert property (
    state_q == S_STAT && TX_READY |=> PHASE == sense_pkg::PH_MSG_IN && TX_DATA == 8'h00)
    else $error("command complete message missing");
  chk_bus_release: assert property (
    state_q == S_MSG && TX_READY |=> !BSY && PHASE == sense_pkg::PH_FREE && CMD_READY)
    else $error("busy not released after message");
  chk_good_key_zero: assert property (
    cmd_take && CMD_OPCODE == sense_pkg::OP_SELF_DIAG && !pend_q |=>
      TX_DATA == 8'h00 && key == 4'h0)
    else $error("diagnostic without error not good");
  // A byte must not move under an initiator that has not taken it yet
  chk_byte_stands: assert property (
    state_q != S_FREE && !TX_READY |=> $stable(TX_DATA))
    else $error("byte changed before it was taken");
  chk_len_limit: assert property (
    state_q == S_DATA |-> cnt_q < limit_q && limit_q <= SENSE_LEN_B)
    else $error("sense readout overran");
  chk_bad_op_sense: assert property (
    cmd_take && bad_op |=> pend_q && TX_DATA == 8'h02)
    else $error("no sense record on check");
  chk_sense_clear: assert property (
    last_byte |=> !pend_q || $past(sw_post || BUS_FREE_ERR))
    else $error("pending error not cleared");

  cov_sense_read: cover property (last_byte ##1 state_q == S_STAT);
  cov_diag_check: cover property (cmd_take && CMD_OPCODE == sense_pkg::OP_SELF_DIAG && pend_q);
  cov_post_clear: cover property (sw_post && last_byte);
  cov_alloc_zero: cover property (cmd_take && CMD_OPCODE == sense_pkg::OP_REQ_SENSE && CMD_ALLOC == 8'h00);
endmodule
`default_nettype wire

// ### tb/initiator_model.sv
`timescale 1ns/1ps
`default_nettype none
module initiator_model (
  input wire logic sys_clk,
  input wire logic cmd_ready,
  input wire logic [2:0] phase,
  input wire logic bsy,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic cmd_valid,
  output logic [7:0] cmd_opcode,
  output logic [7:0] cmd_alloc,
  output logic tx_ready
);
  logic [7:0] q_byte[$];
  logic [2:0] q_phase[$];
  initial begin
    cmd_valid = 1'b0;
    cmd_opcode = 8'h00;
    cmd_alloc = 8'h00;
    tx_ready = 1'b0;
  end
  // One CDB, then every byte up to bus free; stall halves the take rate
  task automatic cmd(input logic [7:0] op, input logic [7:0] alloc, input bit stall);
    int k;
    bit seen;
    q_byte.delete();
    q_phase.delete();
    cmd_opcode <= op;
    cmd_alloc <= alloc;
    cmd_valid <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (cmd_ready !== 1'b1);
    // Released lines show inverted data so a stale copy cannot pass
    cmd_valid <= 1'b0;
    cmd_opcode <= ~op;
    cmd_alloc <= ~alloc;
    seen = 1'b0;
    for (k = 0; k < 200; k++) begin
      tx_ready <= stall ? ~tx_ready : 1'b1;
      @(posedge sys_clk);
      // Reserved tail bytes are recorded but never relied upon
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
        q_byte.push_back(tx_data);
        q_phase.push_back(phase);
      end
      if (bsy === 1'b1) seen = 1'b1;
      else if (seen) break;
    end
    tx_ready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### tb/scsi_sense_diag_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin fail_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module scsi_sense_diag_test;
  logic sys_clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, bus_free_err;
  logic [7:0] wb_adr_i, cmd_opcode, cmd_alloc, tx_data;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic cmd_valid, cmd_ready, bsy, tx_valid, tx_ready;
  logic [2:0] phase;
  int fail_count = 0;
  int n_checks = 0;
  localparam logic [7:0] STAT_CHK = {2'b00, sense_pkg::ST_CHECK, 1'b0};
  localparam logic [7:0] STAT_GOOD = {2'b00, sense_pkg::ST_GOOD, 1'b0};
  // Key, code, qualifier per cause index
  localparam logic [19:0] CODES [23] = '{20'h00000, 20'h20000, 20'h28001, 20'h38001, 20'h38002,
    20'h38003, 20'h38004, 20'h48001, 20'h48002, 20'h48003, 20'h48004, 20'h48005, 20'h48006,
    20'h44400, 20'h44700, 20'h52000, 20'h52400, 20'h52500, 20'h52600, 20'h52C02, 20'h60000,
    20'hB4300, 20'hB8001};
  scsi_sense_diag dut (.SYS_CLK(sys_clk), .RSTN(rstn), .WB_CYC_I(wb_cyc_i), .WB_STB_I(wb_stb_i),
    .WB_WE_I(wb_we_i), .WB_ADR_I(wb_adr_i), .WB_SEL_I(wb_sel_i), .WB_DAT_I(wb_dat_i),
    .WB_DAT_O(wb_dat_o), .WB_ACK_O(wb_ack_o), .CMD_VALID(cmd_valid), .CMD_OPCODE(cmd_opcode),
    .CMD_ALLOC(cmd_alloc), .CMD_READY(cmd_ready), .BUS_FREE_ERR(bus_free_err), .PHASE(phase),
    .BSY(bsy), .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_READY(tx_ready));
  initiator_model ini (.sys_clk(sys_clk), .cmd_ready(cmd_ready), .phase(phase), .bsy(bsy),
    .tx_valid(tx_valid), .tx_data(tx_data), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
    .cmd_alloc(cmd_alloc), .tx_ready(tx_ready));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic end_sim;
    if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do begin
      @(posedge sys_clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic post(input logic [4:0] c, input logic ili, input logic [31:0] rq,
    input logic [31:0] ac);
    wb(1'b1, sense_pkg::ADR_REQ_CNT, 4'hF, rq);
    wb(1'b1, sense_pkg::ADR_ACT_CNT, 4'hF, ac);
    wb(1'b1, sense_pkg::ADR_ERROR, 4'hF, {1'b1, 22'h000000, ili, 3'h0, c});
  endtask
  task automatic expect_end(input int nd, input logic [7:0] st);
    `CHK("byte count", nd + 2, ini.q_byte.size())
    for (int i = 0; i < nd; i++) `CHK("data phase", sense_pkg::PH_DATA_IN, ini.q_phase[i])
    `CHK("status phase", sense_pkg::PH_STATUS, ini.q_phase[nd])
    `CHK("status", st, ini.q_byte[nd])
    `CHK("message phase", sense_pkg::PH_MSG_IN, ini.q_phase[nd + 1])
    `CHK("message", sense_pkg::MSG_COMPLETE, ini.q_byte[nd + 1])
    `CHK("bus free", 5'h01, {bsy, phase, cmd_ready})
  endtask
  task automatic sense_chk(input logic [19:0] code, input logic ili, input logic [31:0] info);
    `CHK("key byte", {2'b00, ili, 1'b0, code[19:16]}, ini.q_byte[2])
    if (ili) `CHK("info", info, {ini.q_byte[3], ini.q_byte[4], ini.q_byte[5], ini.q_byte[6]})
    `CHK("length", sense_pkg::ADD_SENSE_LEN, ini.q_byte[7])
    `CHK("cmd info", 32'h00000000, {ini.q_byte[8], ini.q_byte[9], ini.q_byte[10], ini.q_byte[11]})
    `CHK("code", code[15:0], {ini.q_byte[12], ini.q_byte[13]})
  endtask
  task automatic sc_regs;
    wb(1'b1, sense_pkg::ADR_REQ_CNT, 4'hF, 32'h11223344);
    wb(1'b1, sense_pkg::ADR_REQ_CNT, 4'h2, 32'hAABBCCDD);
    wb(1'b0, sense_pkg::ADR_REQ_CNT, 4'hF, 32'h00000000);
    `CHK("lane write", 32'h1122CC44, rd)
    wb(1'b0, 8'h10, 4'hF, 32'h00000000);
    `CHK("unmapped", 32'h00000000, rd)
    // A post without both end lanes must not leave an error behind
    wb(1'b1, sense_pkg::ADR_ERROR, 4'h1, 32'h80000003);
    ini.cmd(sense_pkg::OP_SELF_DIAG, 8'h00, 1'b0);
    expect_end(0, STAT_GOOD);
    wb(1'b0, sense_pkg::ADR_STATE, 4'hF, 32'h00000000);
    `CHK("state reg", 32'h00000200, rd)
  endtask
  task automatic sc_pending;
    post(sense_pkg::CAUSE_JAM, 1'b1, 32'h00000010, 32'h00000013);
    wb(1'b0, sense_pkg::ADR_ERROR, 4'hF, 32'h00000000);
    `CHK("error reg", 6'h33, rd[8:3])
    ini.cmd(sense_pkg::OP_SELF_DIAG, 8'h00, 1'b1);
    expect_end(0, STAT_CHK);
    wb(1'b0, sense_pkg::ADR_STATE, 4'hF, 32'h00000000);
    `CHK("state reg", 32'h00000213, rd)
    ini.cmd(sense_pkg::OP_REQ_SENSE, 8'h12, 1'b1);
    expect_end(18, STAT_GOOD);
    sense_chk(CODES[3], 1'b1, 32'hFFFFFFFD);
    ini.cmd(sense_pkg::OP_SELF_DIAG, 8'h00, 1'b0);
    expect_end(0, STAT_GOOD);
  endtask
  task automatic sc_table;
    for (int c = 0; c < 23; c++) begin
      if (c > 0) post(5'(c), 1'b0, 32'h00000000, 32'h00000000);
      ini.cmd(sense_pkg::OP_TEST_READY, 8'h00, 1'b0);
      expect_end(0, c > 0 ? STAT_CHK : STAT_GOOD);
      ini.cmd(sense_pkg::OP_REQ_SENSE, 8'h0E, c[0]);
      expect_end(14, STAT_GOOD);
      sense_chk(CODES[c], 1'b0, 32'h00000000);
    end
  endtask
  task automatic sc_alloc_zero;
    post(sense_pkg::CAUSE_NOT_READY, 1'b0, 32'h00000000, 32'h00000000);
    ini.cmd(sense_pkg::OP_REQ_SENSE, 8'h00, 1'b0);
    expect_end(0, STAT_GOOD);
    ini.cmd(sense_pkg::OP_TEST_READY, 8'h00, 1'b0);
    expect_end(0, STAT_GOOD);
  endtask
  task automatic sc_faults;
    bus_free_err <= 1'b1;
    @(posedge sys_clk);
    bus_free_err <= 1'b0;
    @(posedge sys_clk);
    ini.cmd(sense_pkg::OP_REQ_SENSE, 8'h12, 1'b0);
    expect_end(18, STAT_GOOD);
    sense_chk(CODES[21], 1'b0, 32'h00000000);
    ini.cmd(8'h5A, 8'h00, 1'b0);
    expect_end(0, STAT_CHK);
    ini.cmd(sense_pkg::OP_REQ_SENSE, 8'h12, 1'b1);
    expect_end(18, STAT_GOOD);
    sense_chk(CODES[15], 1'b0, 32'h00000000);
  endtask
  initial begin
    rstn = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h00000000;
    bus_free_err = 1'b0;
    repeat (5) @(posedge sys_clk);
    `CHK("reset state", 6'h01, {wb_ack_o, tx_valid, bsy, phase} + 6'h01)
    rstn <= 1'b1;
    @(posedge sys_clk);
    sc_regs();
    sc_pending();
    sc_table();
    sc_alloc_zero();
    sc_faults();
    end_sim();
  end
  // Whole run is under two thousand cycles; this margin only catches a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    end_sim();
  end
endmodule
`default_nettype wire
